// [include/csa_regs.svh]
// Purpose: named constants for the control-store access block
// Assumes: 16-bit datapath, 10-bit micro addresses, 32-bit control words
// Notes: definitions only
`ifndef CSA_REGS_SVH
`define CSA_REGS_SVH

// function-one field codes that select the two access functions
`define CSA_FUNC_READ 4'hA
`define CSA_FUNC_WRITE 4'hB

// address accumulator fields (bit 0 is the lsb here)
`define CSA_ROMSEL_BIT 11
`define CSA_HALF_BIT 10
`define CSA_ADDR_MSB 9

// fixed firmware entry addresses
`define CSA_ENTRY_MAIN 10'h010
`define CSA_ENTRY_TRAP 10'h01F
`define CSA_ENTRY_STUB 10'h1FF

// program counter window and masks for the return dispatch and the rom address
`define CSA_IO_BASE 16'hFE00
`define CSA_IO_MASK 16'hFE00
`define CSA_PC_MASK9 16'h01FF
`define CSA_PC_LOW10 16'h03FF
`define CSA_PC_STEP 16'h0001

// return-index register values
`define CSA_CYC_IDX_RAM 3'h5
`define CSA_CYC_IDX_MAX 3'h5
`define CSA_CYC_REG 5'h05

`endif

// [include/csa_pkg.sv]
// Purpose: types shared by the control-store access block
// Assumes: constants live in csa_regs.svh
// Notes: no imports are used anywhere; names are always scoped
`default_nettype none
package csa_pkg;

  // access sequence, gray coded along idle -> hold -> finish
  typedef enum logic [1:0] {
    CSA_IDLE = 2'b00,
    CSA_HOLD = 2'b01,
    CSA_FINISH = 2'b11
  } csa_phase_t;

  typedef enum logic [1:0] {
    CSA_OP_NONE = 2'h0,
    CSA_OP_READ = 2'h1,
    CSA_OP_WRITE = 2'h2
  } csa_op_t;

  // kind of rom subroutine completing
  typedef enum logic [2:0] {
    CSA_RET_PC_PLAIN = 3'h0,
    CSA_RET_PC_BLOCK = 3'h1,
    CSA_RET_PC_DIVIDE = 3'h2,
    CSA_RET_REGISTER = 3'h3,
    CSA_RET_STUB = 3'h4
  } csa_ret_kind_t;

  // current microinstruction as seen by the access logic
  typedef struct packed {
    logic [3:0] functionOneField;
    logic ramTask;
    logic [15:0] acc;
    logic [15:0] alu;
  } csa_uinstr_t;

  typedef struct packed {
    logic valid;
    csa_ret_kind_t kind;
    logic [15:0] pc;
    logic interruptStop;
    logic divideOk;
    logic [2:0] cycIdx;
  } csa_ret_req_t;

  typedef struct packed {
    logic valid;
    logic [9:0] target;
    logic bankSwitch;
    logic toMain;
    logic [15:0] pc;
  } csa_ret_ans_t;

endpackage
`default_nettype wire

// [src/csa_return_dispatch.sv]
// Purpose: decides where a finishing rom subroutine goes next
// Assumes: one request per cycle at most, answer one cycle later
// Notes: the bank actually entered on a switch is chosen by the sequencer
`timescale 1ns/10ps
`default_nettype none
`include "csa_regs.svh"

module csa_return_dispatch #(
  parameter logic [9:0] SUCC_BASE = 10'h160
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and answer
  input wire csa_pkg::csa_ret_req_t req,
  output var csa_pkg::csa_ret_ans_t ans
);

  typedef struct packed {
    csa_pkg::csa_ret_ans_t ans;
  } csa_rd_state_t;

  csa_rd_state_t st_r;
  csa_rd_state_t st_nxt;
  logic [15:0] pcAdj;

  // pc adjustment, then target choice
  always_comb begin
    st_nxt = '0;
    pcAdj = req.pc;
    if (req.kind == csa_pkg::CSA_RET_PC_BLOCK && req.interruptStop) begin
      pcAdj = req.pc - `CSA_PC_STEP;
    end else if (req.kind == csa_pkg::CSA_RET_PC_DIVIDE && req.divideOk) begin
      pcAdj = req.pc + `CSA_PC_STEP;
    end
    st_nxt.ans.valid = req.valid;
    st_nxt.ans.pc = pcAdj;
    st_nxt.ans.target = `CSA_ENTRY_MAIN;
    st_nxt.ans.toMain = 1'b1;
    unique case (req.kind)
      csa_pkg::CSA_RET_REGISTER: begin
        // index 5 is the successor that returns to ram or the extended bank
        if (req.cycIdx == `CSA_CYC_IDX_RAM) begin
          st_nxt.ans.target = pcAdj[9:0];
          st_nxt.ans.bankSwitch = 1'b1;
          st_nxt.ans.toMain = 1'b0;
        end else begin
          st_nxt.ans.target = SUCC_BASE + {7'h00, req.cycIdx};
          st_nxt.ans.toMain = 1'b0;
        end
      end
      csa_pkg::CSA_RET_STUB: begin
        st_nxt.ans.bankSwitch = 1'b1;
      end
      default: begin
        // pc call: outside the i/o window means back to the main loop
        if ((pcAdj & `CSA_IO_MASK) == `CSA_IO_BASE) begin
          st_nxt.ans.target = 10'((pcAdj & `CSA_PC_MASK9));
          st_nxt.ans.bankSwitch = 1'b1;
          st_nxt.ans.toMain = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ans = st_r.ans;

endmodule // csa_return_dispatch
`default_nettype wire

// [src/csa_control_store_access.sv]
// Purpose: control-store read and write with clock hold, plus return dispatch
// Assumes: the sequencer freezes while holdClock is high; inputs are synchronous
// Notes: control ram is flip-flops; the read-only store sits outside and is
//   addressed only by the micro program counter
//
// Overview of operation
// - read or write halts system clock one cycle
// - write commits at end of first time
// - rom address only from micro pc, mod 1024
// - rom read: only accumulator bits 4-5 matter
// - only primary read-only bank is readable
// - fixed entries: main, trap, bank-return stub
// - stub switches bank then goes to main
// - pc return: main unless pc in window
// - interrupt decrements pc, divide success skips
// - cyclic shift returns via return-index register
// - write: high from first, low from second
// - read: halfword ANDed with next alu result
`timescale 1ns/10ps
`default_nettype none
`include "csa_regs.svh"

module csa_control_store_access #(
  parameter int RAM_DEPTH = 1024,
  parameter int WORD_W = 32,
  parameter logic [9:0] SUCC_BASE = 10'h160
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // current microinstruction and datapath values
  input wire csa_pkg::csa_uinstr_t uinstr,
  input wire logic [9:0] microProgramCounter,
  // primary read-only bank, addressed by romAddr
  output logic [9:0] romAddr,
  input wire logic [WORD_W-1:0] romData,
  // clock control
  output logic holdClock,
  // read result to the destination accumulator
  output logic [15:0] readData,
  output logic readValid,
  // subroutine return dispatch
  input wire csa_pkg::csa_ret_req_t retReq,
  output var csa_pkg::csa_ret_ans_t retAns,
  // fixed entry points
  output logic [9:0] entryMain,
  output logic [9:0] entryTrap,
  output logic [9:0] entryStub
);

  localparam int AW = $clog2(RAM_DEPTH);

  // whole control state of the access sequence
  typedef struct packed {
    csa_pkg::csa_phase_t phase;
    csa_pkg::csa_op_t op;
    logic [AW-1:0] addr;
    logic romSel;
    logic hiHalf;
    logic [15:0] hiWord;
    logic [15:0] rdData;
    logic rdValid;
    logic hold;
  } csa_state_t;

  csa_state_t st_r;
  csa_state_t st_nxt;

  // control ram storage and its write port
  logic [WORD_W-1:0] ramMem [RAM_DEPTH];
  logic ramWe;
  logic [AW-1:0] ramWaddr;
  logic [WORD_W-1:0] ramWdata;

  logic decRead;
  logic decWrite;
  logic accept;
  logic [WORD_W-1:0] srcWord;
  logic [15:0] srcHalf;

  // decode: only ram-related tasks own these function codes
  assign decRead = uinstr.ramTask && (uinstr.functionOneField == `CSA_FUNC_READ);
  assign decWrite = uinstr.ramTask && (uinstr.functionOneField == `CSA_FUNC_WRITE);

  // a new access is taken in idle, or in the finish cycle, where the
  // instruction on the inputs is the one after the held cycle for the first
  // time as a real execution; the hold cycle itself never decodes, which
  // keeps the frozen instruction from being counted twice
  assign accept = (st_r.phase != csa_pkg::CSA_HOLD);

  // the read-only store follows the micro program counter only; during the
  // hold the counter already names the following microinstruction
  assign romAddr = 10'({6'h00, microProgramCounter} & `CSA_PC_LOW10);

  // only the primary bank is wired here; no path reaches the extended bank
  assign srcWord = st_r.romSel ? romData : ramMem[st_r.addr];
  assign srcHalf = st_r.hiHalf ? srcWord[WORD_W-1 -: 16] : srcWord[15:0];

  // sequence and data capture
  always_comb begin
    st_nxt = st_r;
    st_nxt.hold = 1'b0;
    st_nxt.rdValid = 1'b0;
    ramWe = 1'b0;
    ramWaddr = st_r.addr;
    ramWdata = {st_r.hiWord, uinstr.alu};
    unique case (st_r.phase)
      csa_pkg::CSA_IDLE, csa_pkg::CSA_FINISH: begin
        st_nxt.phase = csa_pkg::CSA_IDLE;
        st_nxt.op = csa_pkg::CSA_OP_NONE;
        if (accept && (decRead || decWrite)) begin
          st_nxt.phase = csa_pkg::CSA_HOLD;
          st_nxt.hold = 1'b1;
          st_nxt.hiHalf = uinstr.acc[`CSA_HALF_BIT];
          // ram address comes from the address accumulator
          st_nxt.addr = uinstr.acc[AW-1:0];
          if (decRead) begin
            st_nxt.op = csa_pkg::CSA_OP_READ;
            // for the rom only bits 4-5 (select and half) take effect
            st_nxt.romSel = uinstr.acc[`CSA_ROMSEL_BIT];
          end else begin
            st_nxt.op = csa_pkg::CSA_OP_WRITE;
            st_nxt.romSel = 1'b0;
            // high half is the alu value of the write cycle itself
            st_nxt.hiWord = uinstr.alu;
          end
        end
      end
      csa_pkg::CSA_HOLD: begin
        // exactly one frozen cycle, then the held instruction finishes
        st_nxt.phase = csa_pkg::CSA_FINISH;
        if (st_r.op == csa_pkg::CSA_OP_WRITE) begin
          // low half is the following instruction's alu value; the word is
          // stored at the end of this first time so late bus trouble in the
          // completing cycle cannot corrupt it
          ramWe = 1'b1;
          ramWdata = {st_r.hiWord, uinstr.alu};
        end else begin
          st_nxt.rdData = srcHalf & uinstr.alu;
          st_nxt.rdValid = 1'b1;
        end
      end
      default: begin
        st_nxt.phase = csa_pkg::CSA_IDLE;
        st_nxt.op = csa_pkg::CSA_OP_NONE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{phase: csa_pkg::CSA_IDLE, op: csa_pkg::CSA_OP_NONE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // control ram has no reset; contents survive a processor reset
  always_ff @(posedge clk) begin
    if (ramWe) begin
      ramMem[ramWaddr] <= ramWdata;
    end
  end

  // the hold lasts one cycle and is registered, so the clock control sees
  // a clean level; back-to-back accesses cannot merge into a longer stall
  assign holdClock = st_r.hold;
  assign readData = st_r.rdData;
  assign readValid = st_r.rdValid;

  // firmware entry points are fixed so ram code can reach them
  assign entryMain = `CSA_ENTRY_MAIN;
  assign entryTrap = `CSA_ENTRY_TRAP;
  assign entryStub = `CSA_ENTRY_STUB;

  // subroutine return decisions
  csa_return_dispatch #(
    .SUCC_BASE(SUCC_BASE)
  ) csa_return_dispatch_inst (
    .clk(clk),
    .rst_n(rst_n),
    .req(retReq),
    .ans(retAns)
  );

endmodule // csa_control_store_access
`default_nettype wire

// [tb/csa_rom_model.sv]
// Purpose: primary read-only bank seen by the access block
// Assumes: combinational word, same cycle as its address
// Notes: every address gives a distinct word, so a wrong address shows
`timescale 1ns/10ps
`default_nettype none
module csa_rom_model (
  // address and word
  input wire logic [9:0] romAddr,
  output logic [31:0] romData
);
  // only the primary bank exists here; no second bank is modelled
  assign romData = {romAddr ^ 10'h155, 6'h03, ~romAddr, 6'h0C};
endmodule // csa_rom_model
`default_nettype wire

// [tb/csa_access_properties.sv]
// Purpose: port checker for control store access
// Assumes: one clock, async active-low reset
// Notes: a decode while the hold is high is refused, so it is masked here
`timescale 1ns/10ps
`default_nettype none
module csa_access_checker #(
  parameter int WORD_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access side
  input wire csa_pkg::csa_uinstr_t uinstr,
  input wire logic [9:0] microProgramCounter,
  input wire logic [9:0] romAddr,
  input wire logic [WORD_W-1:0] romData,
  input wire logic holdClock,
  input wire logic [15:0] readData,
  input wire logic readValid,
  // return side
  input wire csa_pkg::csa_ret_req_t retReq,
  input wire csa_pkg::csa_ret_ans_t retAns,
  input wire logic [9:0] entryMain,
  input wire logic [9:0] entryTrap,
  input wire logic [9:0] entryStub
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // decoded accesses that are really taken
  wire logic dec = uinstr.ramTask && !holdClock;
  wire logic rd = dec && uinstr.functionOneField == 4'hA;
  wire logic wr = dec && uinstr.functionOneField == 4'hB;
  wire logic pl = retReq.valid && retReq.kind == csa_pkg::CSA_RET_PC_PLAIN;
  wire logic inW = retReq.pc[15:9] == 7'h7F;
  property p_hold; rd || wr |=> holdClock; endproperty
  a_hold: assert property (p_hold)
    else $error("no hold after access");
  property p_once; holdClock |=> !holdClock; endproperty
  a_once: assert property (p_once)
    else $error("hold longer than one cycle");
  property p_idle; !(rd || wr) |=> !holdClock; endproperty
  a_idle: assert property (p_idle)
    else $error("hold without access");
  property p_rdv; rd |=> ##1 readValid; endproperty
  a_rdv: assert property (p_rdv)
    else $error("read result missing");
  property p_romd;
    rd && uinstr.acc[11:10] == 2'h3 |=> ##1
      readData == ($past(romData[WORD_W-1 -: 16]) & $past(uinstr.alu));
  endproperty
  a_romd: assert property (p_romd)
    else $error("rom read data wrong");
  property p_rom; romAddr == microProgramCounter; endproperty
  a_rom: assert property (p_rom)
    else $error("rom address not micro pc");
  property p_ent;
    entryMain == 10'h010 && entryTrap == 10'h01F && entryStub == 10'h1FF;
  endproperty
  a_ent: assert property (p_ent)
    else $error("entry address wrong");
  property p_main;
    pl && !inW |=> retAns.valid && retAns.toMain && retAns.target == 10'h010;
  endproperty
  a_main: assert property (p_main)
    else $error("plain return not to main");
  property p_win;
    pl && inW |=> retAns.bankSwitch && retAns.target == {1'h0, $past(retReq.pc[8:0])};
  endproperty
  a_win: assert property (p_win)
    else $error("window return target wrong");
  property p_stub;
    retReq.valid && retReq.kind == csa_pkg::CSA_RET_STUB |=>
      retAns.toMain && retAns.bankSwitch;
  endproperty
  a_stub: assert property (p_stub)
    else $error("stub return wrong");
  // main scenarios
  c_wr: cover property (wr);
  c_rom: cover property (rd && uinstr.acc[11]);
  c_sw: cover property (retAns.valid && retAns.bankSwitch);
endmodule // csa_access_checker
bind csa_control_store_access csa_access_checker #(.WORD_W(WORD_W)) csa_access_checker_inst (.*);
`default_nettype wire

// [tb/csa_control_store_access_tb_top.sv]
// Purpose: self-checking bench for control store access
// Assumes: inputs change 1 ns after the rising edge
// Notes: latencies are fixed, so waits are fixed steps
`timescale 1ns/10ps
`default_nettype none
module csa_control_store_access_tb_top;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  csa_pkg::csa_uinstr_t uinstr = '0;
  logic [9:0] microProgramCounter = 10'h000;
  logic [9:0] romAddr;
  logic [31:0] romData;
  logic holdClock;
  logic [15:0] readData;
  logic readValid;
  csa_pkg::csa_ret_req_t retReq = '0;
  csa_pkg::csa_ret_ans_t retAns;
  logic [9:0] entryMain;
  logic [9:0] entryTrap;
  logic [9:0] entryStub;
  int err_total = 0;
  int n_checks = 0;
  csa_control_store_access csa_control_store_access_inst (.clk, .rst_n, .uinstr,
    .microProgramCounter, .romAddr, .romData, .holdClock, .readData, .readValid,
    .retReq, .retAns, .entryMain, .entryTrap, .entryStub);
  csa_rom_model csa_rom_model_inst (.romAddr, .romData);
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one access: op and alu of the first cycle, then op and alu of the held one;
  // operands are settled values, never a slow memory read; no bus-zero test and
  // no constant memory is ever asked of the block
  task automatic acc1(input logic [3:0] op, input logic [15:0] a, input logic [15:0] d,
    input logic [3:0] op2, input logic [15:0] d2);
    uinstr = '{op, 1'h1, a, d};
    step();
    chk(holdClock, 1'h1);
    // the held instruction follows at once; nothing else stalls it
    uinstr = '{op2, 1'h1, a, d2};
  endtask
  // write then read both halves back to back
  task automatic t_ram();
    acc1(4'hB, 16'h0123, 16'hBEEF, 4'h0, 16'h1234);
    step();
    chk(holdClock, 1'h0);
    acc1(4'hA, 16'h0523, 16'h0000, 4'h0, 16'hFF0F);
    step();
    chk(readValid, 1'h1);
    chk(readData, 16'hBE0F);
    acc1(4'hA, 16'h0123, 16'h0000, 4'h0, 16'hFFFF);
    step();
    chk(readData, 16'h1234);
    $display("t_ram done");
  endtask
  // junk in the other accumulator bits must not matter
  task automatic t_rom(input logic [15:0] a, input logic [15:0] e);
    microProgramCounter = 10'h2AA;
    acc1(4'hA, a, 16'h0000, 4'h0, 16'hFFFF);
    microProgramCounter = 10'h0C3; // only the following instruction's address counts
    step();
    chk(readData, e);
    $display("t_rom done");
  endtask
  // non-ram task and a decode in the hold cycle are both ignored
  task automatic t_refuse();
    uinstr = '{4'hB, 1'h0, 16'h0000, 16'h0000};
    step();
    chk(holdClock, 1'h0);
    acc1(4'hA, 16'h0123, 16'h0000, 4'hB, 16'h00FF);
    step();
    chk(holdClock, 1'h0);
    chk(readData, 16'h0034);
    uinstr = '0;
    step();
    $display("t_refuse done");
  endtask
  // reset in the hold cycle clears the outputs; control ram keeps its word
  task automatic t_reset();
    acc1(4'hA, 16'h0523, 16'h0000, 4'h0, 16'hFFFF);
    rst_n = 1'h0;
    #1;
    chk(holdClock, 1'h0);
    chk(readData, 16'h0000);
    step();
    chk(readValid, 1'h0);
    rst_n = 1'h1;
    acc1(4'hA, 16'h0523, 16'h0000, 4'h0, 16'hFFFF);
    step();
    chk(readValid, 1'h1);
    chk(readData, 16'hBEEF);
    $display("t_reset done");
  endtask
  // both pc flags set: only the matching kind may use them
  task automatic ret1(input csa_pkg::csa_ret_kind_t k, input logic [15:0] pc,
    input logic [2:0] ix, input logic [9:0] t, input logic [15:0] pn, input logic [1:0] bm);
    retReq = '{1'h1, k, pc, 1'h1, 1'h1, ix};
    step();
    chk(retAns.valid, 1'h1);
    chk(retAns.target, t);
    chk(retAns.pc, pn);
    chk(retAns.toMain, bm[0]);
    if (k != csa_pkg::CSA_RET_REGISTER || ix == 3'h5) begin
      chk(retAns.bankSwitch, bm[1]);
    end
  endtask
  task automatic t_ret();
    ret1(csa_pkg::CSA_RET_PC_PLAIN, 16'h1234, 3'h0, 10'h010, 16'h1234, 2'h1);
    ret1(csa_pkg::CSA_RET_PC_PLAIN, 16'hFE05, 3'h0, 10'h005, 16'hFE05, 2'h2);
    ret1(csa_pkg::CSA_RET_PC_BLOCK, 16'hFE00, 3'h0, 10'h010, 16'hFDFF, 2'h1);
    ret1(csa_pkg::CSA_RET_PC_DIVIDE, 16'hFDFF, 3'h0, 10'h000, 16'hFE00, 2'h2);
    ret1(csa_pkg::CSA_RET_REGISTER, 16'h12F3, 3'h5, 10'h2F3, 16'h12F3, 2'h2);
    ret1(csa_pkg::CSA_RET_REGISTER, 16'h12F3, 3'h2, 10'h162, 16'h12F3, 2'h0);
    ret1(csa_pkg::CSA_RET_STUB, 16'h1234, 3'h0, 10'h010, 16'h1234, 2'h3);
    // valid stayed up across the back-to-back requests; drop it once here
    retReq.valid = 1'h0;
    $display("t_ret done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    #40000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (16) step();
    chk(holdClock, 1'h0);
    rst_n = 1'h1;
    chk({entryMain, 6'h00}, 16'h0400);
    chk(entryTrap, 10'h01F);
    chk(entryStub, 10'h1FF);
    t_ram();
    t_rom(16'hFFFF, {10'h0C3 ^ 10'h155, 6'h03});
    t_rom(16'hFBFF, {~10'h0C3, 6'h0C});
    t_refuse();
    t_reset();
    t_ret();
    report_and_stop();
  end
endmodule // csa_control_store_access_tb_top
`default_nettype wire
